//--- rtl/mdw_pkg.sv
package mdw_pkg;
   // Clock and overload time base
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          OVL_TICK_NS    = 100_000_000;
   localparam int          OVL_TICK_DEF   = OVL_TICK_NS / CLK_PERIOD_NS;
   localparam int          TICK_W         = 22;
   // Deviation in 0.1 degree units, limits in 0.01 rev
   localparam logic [23:0] DEG10_PER_CREV = 24'h000024;
   localparam logic [23:0] OVL_DEV_DEG10  = 24'h000012;
   localparam logic [33:0] TRAVEL_RANGE   = 34'h080000000;
   // Setting ranges
   localparam logic [15:0] DEV_MIN        = 16'h0001;
   localparam logic [15:0] DEV_MAX        = 16'h7530;
   localparam logic [15:0] VOLT_MIN       = 16'h0096;
   localparam logic [15:0] VOLT_MAX       = 16'h0276;
   localparam logic [15:0] TEMP_MIN       = 16'h0028;
   localparam logic [15:0] TEMP_MAX       = 16'h0055;
   localparam logic [15:0] OVLT_MIN       = 16'h0001;
   localparam logic [15:0] OVLT_MAX       = 16'h012c;
   localparam logic [15:0] SPD_MIN        = 16'h0001;
   localparam logic [15:0] SPD_MAX        = 16'h1388;
   // Electronic gear resolution window, plain defaults
   localparam logic [19:0] GEAR_MIN_DEF   = 20'h000c8;
   localparam logic [19:0] GEAR_MAX_DEF   = 20'h0c800;
   // Pin synchroniser lanes
   localparam int          PIN_RES        = 0;
   localparam int          PIN_HOME       = 1;
   localparam int          PIN_W          = 2;

   typedef enum logic {MDW_MODE_NORMAL, MDW_MODE_CURRENT} mdw_mode_t;

   typedef struct packed {
      logic [14:0] dev_on;
      logic [14:0] dev_off;
      logic [9:0]  ov;
      logic [9:0]  uv;
      logic [7:0]  ot;
      logic [8:0]  ovl_time;
      logic [12:0] os;
      logic        abn_en;
      logic        auto_ret;
   } mdw_cfg_t;

   typedef struct packed {
      logic [23:0] dev_abs;
      logic [33:0] travel_abs;
      logic [9:0]  volt;
      logic [7:0]  temp;
      logic [12:0] speed;
      logic        cur_limit;
      logic [19:0] gear_res;
   } mdw_meas_t;

   typedef struct packed {
      logic dev_on;
      logic dev_off;
      logic overheat;
      logic overvolt;
      logic undervolt;
      logic overload;
      logic overspeed;
      logic opdata_err;
      logic abn_opdata;
      logic gear_err;
   } mdw_warn_t;

   localparam mdw_cfg_t CFG_RST = '{
      dev_on:   15'h012c,
      dev_off:  15'h2710,
      ov:       10'h276,
      uv:       10'h0b4,
      ot:       8'h55,
      ovl_time: 9'h032,
      os:       13'h1194,
      abn_en:   1'b0,
      auto_ret: 1'b0
   };
endpackage : mdw_pkg

//--- rtl/mdw_warning_monitor.sv
// Summary of operation
// [RL1] Warning output is on whenever any warning is active.
// [RL2] Resolution select on refuses home return and raises abnormal data warning.
// [RL3] Current on: deviation above current-on limit raises deviation warning.
// [RL4] Current off: deviation above current-off limit warns only with auto return.
// [RL5] Temperature above overheat limit raises overheat warning.
// [RL6] Supply above overvoltage limit raises overvoltage warning.
// [RL7] Supply below undervoltage limit raises undervoltage warning.
// [RL8] Overload warns only after condition held for the overload time.
// [RL9] Normal mode: deviation of 1.8 degrees or more is overload.
// [RL10] Current control mode: current at its limit is overload.
// [RL11] Speed above overspeed limit raises overspeed warning.
// [RL12] Resolution select change while current on raises operation data error.
// [RL13] With enable set, travel beyond control range raises operation data error.
// [RL14] Gear resolution outside permitted range raises gear setting error.
// [RL15] Current-on limit settable 0.01 to 300.00 rev, default 3.00.
// [RL16] Current-off limit defaults to 100.00 rev.
// [RL17] Abnormal data warning enable is one bit, default off.
// [RL18] Warning output drops once every warning has cleared.
`timescale 1ns/100ps
module mdw_warning_monitor
   import mdw_pkg::*;
#(
   parameter int          OVL_TICK_CYC = OVL_TICK_DEF,
   parameter logic [19:0] GEAR_MIN     = GEAR_MIN_DEF,
   parameter logic [19:0] GEAR_MAX     = GEAR_MAX_DEF
) (
   input  wire logic      clk,
   input  wire logic      arst_n,
   input  wire logic      res_select_pin,
   input  wire logic      home_req_pin,
   input  wire logic      current_on,
   input  wire mdw_mode_t ctrl_mode,
   input  wire mdw_meas_t meas,
   input  wire logic      cfg_wr,
   input  wire mdw_cfg_t  cfg_in,
   input  wire logic      warn_clear,
   output wire logic      warning_output,
   output wire mdw_warn_t warn_status,
   output wire logic      home_go,
   output wire logic      home_refused,
   output wire mdw_cfg_t  cfg_active
);

   function automatic logic [15:0] mdw_clamp(
      input logic [15:0] v,
      input logic [15:0] lo,
      input logic [15:0] hi
   );
      mdw_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : mdw_clamp

   function automatic logic [23:0] mdw_crev_to_deg10(
      input logic [14:0] crev
   );
      mdw_crev_to_deg10 = 24'({9'h000, crev} * DEG10_PER_CREV);
   endfunction : mdw_crev_to_deg10

   logic [PIN_W-1:0]  pin_s1_r;
   logic [PIN_W-1:0]  pin_s2_r;
   logic [PIN_W-1:0]  pin_s3_r;
   mdw_cfg_t          cfg_r;
   mdw_cfg_t          cfg_cl;
   mdw_warn_t         warn_r;
   mdw_warn_t         warn_nxt;
   logic              warn_out_r;
   logic              home_go_r;
   logic              home_ref_r;
   logic [TICK_W-1:0] tick_cnt_r;
   logic [TICK_W-1:0] tick_cnt_nxt;
   logic [8:0]        ovl_cnt_r;
   logic [8:0]        ovl_cnt_nxt;
   logic              opdata_r;
   logic              opdata_nxt;
   logic              res_on;
   logic              res_changed;
   logic              home_req;
   logic [23:0]       lim_on_deg10;
   logic [23:0]       lim_off_deg10;
   logic              ovl_cond;
   logic              tick_end;
   logic              travel_over;
   logic              opdata_set;

   // Two-stage pin synchronisers, third stage for edges
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               pin_s1_r[gi] <= 1'b0;
               pin_s2_r[gi] <= 1'b0;
               pin_s3_r[gi] <= 1'b0;
            end else begin
               pin_s1_r[gi] <= (gi == PIN_RES) ? res_select_pin : home_req_pin;
               pin_s2_r[gi] <= pin_s1_r[gi];
               pin_s3_r[gi] <= pin_s2_r[gi];
            end
         end
      end
   endgenerate

   assign res_on      = pin_s2_r[PIN_RES];
   assign res_changed = pin_s2_r[PIN_RES] ^ pin_s3_r[PIN_RES];
   assign home_req    = pin_s2_r[PIN_HOME] & ~pin_s3_r[PIN_HOME];

   // Settings clamped into their ranges on write
   assign cfg_cl = '{
      dev_on:   15'(mdw_clamp(16'(cfg_in.dev_on), DEV_MIN, DEV_MAX)), // see [RL15]
      dev_off:  15'(mdw_clamp(16'(cfg_in.dev_off), DEV_MIN, DEV_MAX)),
      ov:       10'(mdw_clamp(16'(cfg_in.ov), VOLT_MIN, VOLT_MAX)),
      uv:       10'(mdw_clamp(16'(cfg_in.uv), VOLT_MIN, VOLT_MAX)),
      ot:       8'(mdw_clamp(16'(cfg_in.ot), TEMP_MIN, TEMP_MAX)),
      ovl_time: 9'(mdw_clamp(16'(cfg_in.ovl_time), OVLT_MIN, OVLT_MAX)),
      os:       13'(mdw_clamp(16'(cfg_in.os), SPD_MIN, SPD_MAX)),
      abn_en:   cfg_in.abn_en, // see [RL17]
      auto_ret: cfg_in.auto_ret
   };

   // Defaults held from reset until first write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= CFG_RST; // see [RL15] see [RL16] see [RL17]
      end else if (cfg_wr) begin
         cfg_r <= cfg_cl;
      end
   end

   assign lim_on_deg10  = mdw_crev_to_deg10(cfg_r.dev_on);
   assign lim_off_deg10 = mdw_crev_to_deg10(cfg_r.dev_off);

   // Overload condition depends on control mode
   assign ovl_cond = (ctrl_mode == MDW_MODE_NORMAL) ?
                     (meas.dev_abs >= OVL_DEV_DEG10) : // see [RL9]
                     meas.cur_limit;                   // see [RL10]

   // Overload persistence timer in 0.1 s ticks
   assign tick_end     = (tick_cnt_r == TICK_W'(OVL_TICK_CYC - 1));
   assign tick_cnt_nxt = (!ovl_cond || tick_end) ? '0 : tick_cnt_r + 1'b1;
   assign ovl_cnt_nxt  = !ovl_cond ? '0 :
                         (tick_end && (ovl_cnt_r != 9'(OVLT_MAX))) ?
                         ovl_cnt_r + 1'b1 : ovl_cnt_r; // see [RL8]

   // Operation data error is sticky; set wins over clear
   assign travel_over = cfg_r.abn_en & (meas.travel_abs > TRAVEL_RANGE); // see [RL13]
   assign opdata_set  = (current_on & res_changed) | travel_over; // see [RL12]
   assign opdata_nxt  = opdata_set | (opdata_r & ~warn_clear);

   assign warn_nxt = '{
      dev_on:     current_on & (meas.dev_abs > lim_on_deg10), // see [RL3]
      dev_off:    ~current_on & cfg_r.auto_ret &
                  (meas.dev_abs > lim_off_deg10), // see [RL4]
      overheat:   meas.temp > cfg_r.ot, // see [RL5]
      overvolt:   meas.volt > cfg_r.ov, // see [RL6]
      undervolt:  meas.volt < cfg_r.uv, // see [RL7]
      overload:   ovl_cond & (ovl_cnt_r >= cfg_r.ovl_time), // see [RL8]
      overspeed:  meas.speed > cfg_r.os, // see [RL11]
      opdata_err: opdata_nxt,
      abn_opdata: res_on, // see [RL2]
      gear_err:   (meas.gear_res < GEAR_MIN) |
                  (meas.gear_res > GEAR_MAX) // see [RL14]
   };

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_r <= '0;
         ovl_cnt_r  <= '0;
         opdata_r   <= 1'b0;
         warn_r     <= '0;
         warn_out_r <= 1'b0;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
         ovl_cnt_r  <= ovl_cnt_nxt;
         opdata_r   <= opdata_nxt;
         warn_r     <= warn_nxt;
         warn_out_r <= |warn_nxt; // see [RL1] see [RL18]
      end
   end

   // Home return start or refusal, one-cycle pulses
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         home_go_r  <= 1'b0;
         home_ref_r <= 1'b0;
      end else begin
         home_go_r  <= home_req & ~res_on;
         home_ref_r <= home_req & res_on; // see [RL2]
      end
   end

   assign warning_output = warn_out_r;
   assign warn_status    = warn_r;
   assign home_go        = home_go_r;
   assign home_refused   = home_ref_r;
   assign cfg_active     = cfg_r;

   a_warn_out_any: assert property ( // see [RL1]
      @(posedge clk) disable iff (!arst_n)
      (|warn_status) |-> warning_output)
      else $error("Warning output low with a warning active");

   a_warn_out_idle: assert property ( // see [RL18]
      @(posedge clk) disable iff (!arst_n)
      (warn_status == '0) |-> !warning_output)
      else $error("Warning output high with no warning active");

   a_home_refuse: assert property ( // see [RL2]
      @(posedge clk) disable iff (!arst_n)
      (home_req && res_on) |=> (home_refused && !home_go && warn_status.abn_opdata))
      else $error("Home return not refused while resolution select on");

   a_dev_on_warn: assert property ( // see [RL3]
      @(posedge clk) disable iff (!arst_n)
      (current_on && meas.dev_abs > 24'({9'h000, cfg_r.dev_on} * DEG10_PER_CREV))
      |=> warn_status.dev_on)
      else $error("Current-on deviation warning missed");

   a_dev_off_gate: assert property ( // see [RL4]
      @(posedge clk) disable iff (!arst_n)
      (current_on || !cfg_r.auto_ret) |=> !warn_status.dev_off)
      else $error("Current-off deviation warning without auto return");

   a_overheat: assert property ( // see [RL5]
      @(posedge clk) disable iff (!arst_n)
      (meas.temp > cfg_r.ot) |=> warn_status.overheat)
      else $error("Overheat warning missed");

   a_overvolt: assert property ( // see [RL6]
      @(posedge clk) disable iff (!arst_n)
      (meas.volt > cfg_r.ov) |=> warn_status.overvolt)
      else $error("Overvoltage warning missed");

   a_undervolt: assert property ( // see [RL7]
      @(posedge clk) disable iff (!arst_n)
      (meas.volt < cfg_r.uv) |=> warn_status.undervolt)
      else $error("Undervoltage warning missed");

   a_overload_early: assert property ( // see [RL8]
      @(posedge clk) disable iff (!arst_n)
      (ovl_cnt_r < cfg_r.ovl_time) |=> !warn_status.overload)
      else $error("Overload warning before overload time");

   a_ovl_normal: assert property ( // see [RL9]
      @(posedge clk) disable iff (!arst_n)
      (ctrl_mode == MDW_MODE_NORMAL && meas.dev_abs < OVL_DEV_DEG10)
      |=> (!warn_status.overload && ovl_cnt_r == '0))
      else $error("Overload in normal mode below 1.8 degrees");

   a_ovl_current: assert property ( // see [RL10]
      @(posedge clk) disable iff (!arst_n)
      (ctrl_mode == MDW_MODE_CURRENT && !meas.cur_limit)
      |=> (!warn_status.overload && ovl_cnt_r == '0))
      else $error("Overload in current mode without current limit");

   a_overspeed: assert property ( // see [RL11]
      @(posedge clk) disable iff (!arst_n)
      (meas.speed > cfg_r.os) |=> warn_status.overspeed)
      else $error("Overspeed warning missed");

   a_res_change: assert property ( // see [RL12]
      @(posedge clk) disable iff (!arst_n)
      (current_on && $changed(pin_s2_r[PIN_RES]))
      |=> warn_status.opdata_err)
      else $error("Resolution change while current on not flagged");

   a_travel_range: assert property ( // see [RL13]
      @(posedge clk) disable iff (!arst_n)
      (cfg_r.abn_en && meas.travel_abs > TRAVEL_RANGE) |=> warn_status.opdata_err)
      else $error("Travel beyond control range not flagged");

   a_gear_range: assert property ( // see [RL14]
      @(posedge clk) disable iff (!arst_n)
      (meas.gear_res > GEAR_MAX || meas.gear_res < GEAR_MIN) |=> warn_status.gear_err)
      else $error("Gear resolution out of range not flagged");

   a_dev_on_clamp: assert property ( // see [RL15]
      @(posedge clk) disable iff (!arst_n)
      (cfg_wr && cfg_in.dev_on == '0) |=> (cfg_active.dev_on == 15'(DEV_MIN)))
      else $error("Current-on limit not clamped to minimum");

   a_dev_on_max: assert property ( // see [RL15]
      @(posedge clk) disable iff (!arst_n)
      (cfg_wr && cfg_in.dev_on > 15'(DEV_MAX)) |=> (cfg_active.dev_on == 15'(DEV_MAX)))
      else $error("Current-on limit not clamped to maximum");

   a_dev_off_warn: assert property ( // see [RL4]
      @(posedge clk) disable iff (!arst_n)
      (!current_on && cfg_r.auto_ret && meas.dev_abs > 24'({9'h000, cfg_r.dev_off} * DEG10_PER_CREV))
      |=> warn_status.dev_off)
      else $error("Current-off deviation warning missed");

   a_overload_fire: assert property ( // see [RL8]
      @(posedge clk) disable iff (!arst_n)
      (ovl_cond && ovl_cnt_r >= cfg_r.ovl_time) |=> warn_status.overload)
      else $error("Overload warning missed after overload time");

   a_home_accept: assert property ( // see [RL2]
      @(posedge clk) disable iff (!arst_n)
      (home_req && !res_on) |=> (home_go && !home_refused))
      else $error("Home return not started with resolution select off");

   a_abn_level: assert property ( // see [RL2]
      @(posedge clk) disable iff (!arst_n)
      res_on |=> warn_status.abn_opdata)
      else $error("Abnormal data warning missed with resolution select on");

   a_opdata_hold: assert property ( // see [RL12]
      @(posedge clk) disable iff (!arst_n)
      (warn_status.opdata_err && !warn_clear) |=> warn_status.opdata_err)
      else $error("Operation data error dropped without clear");

   a_opdata_set_wins: assert property ( // see [RL12]
      @(posedge clk) disable iff (!arst_n)
      (warn_clear && opdata_set) |=> warn_status.opdata_err)
      else $error("Clear beat a new operation data error");

endmodule : mdw_warning_monitor

//--- verif/mdw_host_model.sv
`timescale 1ns/100ps
module mdw_host_model
   import mdw_pkg::*;
(
   input  wire logic clk,
   output logic      res_select_pin,
   output logic      home_req_pin,
   output logic      current_on,
   output mdw_mode_t ctrl_mode,
   output mdw_meas_t meas,
   output logic      cfg_wr,
   output mdw_cfg_t  cfg_in,
   output logic      warn_clear
);
   // Quiet machine: mid supply, cool, gear in range
   initial begin
      res_select_pin = 1'b0;
      home_req_pin   = 1'b0;
      current_on     = 1'b0;
      ctrl_mode      = MDW_MODE_NORMAL;
      meas           = '0;
      meas.volt      = 10'h0f0;
      meas.temp      = 8'h19;
      meas.gear_res  = 20'h003e8;
      cfg_wr         = 1'b0;
      cfg_in         = CFG_RST;
      warn_clear     = 1'b0;
   end

   task put_meas(input mdw_meas_t m);
      @(posedge clk);
      #1 meas = m;
   endtask : put_meas

   task put_ctl(input logic cur, input mdw_mode_t md);
      @(posedge clk);
      #1 current_on = cur;
      ctrl_mode = md;
   endtask : put_ctl

   task put_pins(input logic res, input logic home);
      @(posedge clk);
      #1 res_select_pin = res;
      home_req_pin = home;
   endtask : put_pins

   task write_cfg(input mdw_cfg_t c);
      @(posedge clk);
      #1 cfg_in = c;
      cfg_wr = 1'b1;
      @(posedge clk);
      #1 cfg_wr = 1'b0;
   endtask : write_cfg

   task pulse_clear();
      @(posedge clk);
      #1 warn_clear = 1'b1;
      @(posedge clk);
      #1 warn_clear = 1'b0;
   endtask : pulse_clear
endmodule : mdw_host_model

//--- verif/mdw_warning_monitor_bench.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
   $display("wrong value %s exp %h got %h", nm, ex, got); end end
module mdw_warning_monitor_bench;
   import mdw_pkg::*;
   localparam int N = 4;
   logic      clk = 1'b0;
   logic      arst_n = 1'b0;
   logic      res_select_pin, home_req_pin, current_on, cfg_wr, warn_clear;
   logic      warning_output, home_go, home_refused;
   mdw_mode_t ctrl_mode;
   mdw_meas_t meas, m, m0;
   mdw_cfg_t  cfg_in, cfg_active, c;
   mdw_warn_t warn_status;
   int        n_fail = 0;
   int        checks_done = 0;

   always #20 clk = ~clk;

   mdw_host_model i_host (.clk(clk), .res_select_pin(res_select_pin), .home_req_pin(home_req_pin),
      .current_on(current_on), .ctrl_mode(ctrl_mode), .meas(meas), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
      .warn_clear(warn_clear));

   mdw_warning_monitor #(.OVL_TICK_CYC(N)) i_dut (.clk(clk), .arst_n(arst_n),
      .res_select_pin(res_select_pin), .home_req_pin(home_req_pin), .current_on(current_on),
      .ctrl_mode(ctrl_mode), .meas(meas), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .warn_clear(warn_clear),
      .warning_output(warning_output), .warn_status(warn_status), .home_go(home_go),
      .home_refused(home_refused), .cfg_active(cfg_active));

   task wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_n

   task chk_warn(input mdw_warn_t ex);
      `CHK("warn_status", ex, warn_status)
      `CHK("warning_output", |ex, warning_output)
   endtask : chk_warn

   task meas_go(input mdw_meas_t mm, input mdw_warn_t ex);
      i_host.put_meas(mm);
      wait_n(2);
      chk_warn(ex);
   endtask : meas_go

   task home_try(input logic res, input logic go_ex, input logic rf_ex);
      logic go;
      logic rf;
      go = 1'b0;
      rf = 1'b0;
      i_host.put_pins(res, 1'b1);
      repeat (6) begin
         wait_n(1);
         go = go | home_go;
         rf = rf | home_refused;
      end
      `CHK("home_go", go_ex, go)
      `CHK("home_refused", rf_ex, rf)
      i_host.put_pins(res, 1'b0);
   endtask : home_try

   task end_test(input string nm);
      $display("test %s done", nm);
   endtask : end_test

   task tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (2000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      c = CFG_RST;
      wait_n(5);
      m0 = meas;
      arst_n = 1'b1;
      wait_n(1);
      `CHK("dev_on", 15'h012c, cfg_active.dev_on)
      `CHK("dev_off", 15'h2710, cfg_active.dev_off)
      `CHK("abn_en", 1'b0, cfg_active.abn_en)
      chk_warn('0);
      end_test("reset");
      m = m0;
      m.temp = 8'h56;
      meas_go(m, 10'h080);
      m.temp = 8'h55;
      meas_go(m, '0);
      m = m0;
      m.volt = 10'h277;
      meas_go(m, 10'h040);
      m.volt = 10'h0b3;
      meas_go(m, 10'h020);
      m.volt = 10'h0b4;
      meas_go(m, '0);
      m = m0;
      m.speed = 13'h1195;
      meas_go(m, 10'h008);
      m.speed = 13'h1194;
      meas_go(m, '0);
      end_test("limits");
      i_host.put_ctl(1'b1, MDW_MODE_CURRENT);
      m = m0;
      m.dev_abs = 24'h002a31;
      meas_go(m, 10'h200);
      m.dev_abs = 24'h002a30;
      meas_go(m, '0);
      i_host.put_ctl(1'b0, MDW_MODE_CURRENT);
      m.dev_abs = 24'h057e41;
      meas_go(m, '0);
      c.auto_ret = 1'b1;
      i_host.write_cfg(c);
      wait_n(1);
      chk_warn(10'h100);
      m.dev_abs = 24'h057e40;
      meas_go(m, '0);
      end_test("deviation");
      c = CFG_RST;
      c.ovl_time = 9'h003;
      i_host.write_cfg(c);
      i_host.put_ctl(1'b1, MDW_MODE_NORMAL);
      m = m0;
      m.dev_abs = 24'h000011;
      i_host.put_meas(m);
      wait_n(14);
      chk_warn('0);
      m.dev_abs = 24'h000012;
      i_host.put_meas(m);
      wait_n(11);
      chk_warn('0);
      wait_n(3);
      chk_warn(10'h010);
      meas_go(m0, '0);
      i_host.put_ctl(1'b1, MDW_MODE_CURRENT);
      m.cur_limit = 1'b1;
      i_host.put_meas(m);
      wait_n(14);
      chk_warn(10'h010);
      meas_go(m0, '0);
      end_test("overload");
      home_try(1'b0, 1'b1, 1'b0);
      i_host.put_pins(1'b1, 1'b0);
      wait_n(5);
      chk_warn(10'h006);
      home_try(1'b1, 1'b0, 1'b1);
      i_host.put_pins(1'b0, 1'b0);
      wait_n(5);
      chk_warn(10'h004);
      i_host.pulse_clear();
      wait_n(2);
      chk_warn('0);
      i_host.put_ctl(1'b0, MDW_MODE_CURRENT);
      i_host.put_pins(1'b1, 1'b0);
      wait_n(5);
      chk_warn(10'h002);
      i_host.put_pins(1'b0, 1'b0);
      wait_n(5);
      chk_warn('0);
      end_test("resolution");
      c = CFG_RST;
      i_host.write_cfg(c);
      m = m0;
      m.travel_abs = 34'h080000001;
      meas_go(m, '0);
      c.abn_en = 1'b1;
      i_host.write_cfg(c);
      wait_n(1);
      chk_warn(10'h004);
      i_host.pulse_clear();
      wait_n(1);
      chk_warn(10'h004);
      m.travel_abs = 34'h080000000;
      i_host.put_meas(m);
      i_host.pulse_clear();
      wait_n(2);
      chk_warn('0);
      end_test("travel");
      m = m0;
      m.gear_res = 20'h000c7;
      meas_go(m, 10'h001);
      m.gear_res = 20'h0c801;
      meas_go(m, 10'h001);
      m.gear_res = 20'h000c8;
      meas_go(m, '0);
      end_test("gear");
      c = CFG_RST;
      c.dev_on = 15'h0000;
      i_host.write_cfg(c);
      `CHK("dev_on", 15'h0001, cfg_active.dev_on)
      c.dev_on = 15'h7fff;
      i_host.write_cfg(c);
      `CHK("dev_on", 15'h7530, cfg_active.dev_on)
      c.dev_on = 15'h7530;
      i_host.write_cfg(c);
      `CHK("dev_on", 15'h7530, cfg_active.dev_on)
      end_test("settings");
      tally_and_finish();
   end
endmodule : mdw_warning_monitor_bench
